// ### hdl/iox_params.svh
// Offsets, reset values and timing counts of the port expander core.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef IOX_PARAMS_SVH
`define IOX_PARAMS_SVH

// Register byte offsets on the APB
`define IOX_OFS_INPUT    8'h00
`define IOX_OFS_OUTPUT   8'h04
`define IOX_OFS_POLARITY 8'h08
`define IOX_OFS_CONFIG   8'h0C
`define IOX_OFS_STATUS   8'h10

// Reset values
`define IOX_RST_OUTPUT   8'hFF
`define IOX_RST_POLARITY 8'h00
`define IOX_RST_CONFIG   8'hFF

// Status field positions
`define IOX_STS_IRQ_BIT  0
`define IOX_STS_RDY_BIT  1

// Timing, in ns, and the system clock period in ns
`define IOX_CLK_PERIOD_NS    100
`define IOX_IRQ_VALID_NS     4000
`define IOX_IRQ_CLEAR_NS     4000
`define IOX_IRQ_VALID_CYC    (`IOX_IRQ_VALID_NS / `IOX_CLK_PERIOD_NS)
`define IOX_IRQ_CLEAR_CYC    (`IOX_IRQ_CLEAR_NS / `IOX_CLK_PERIOD_NS)

// Reset release stretch, in clock cycles
`define IOX_RST_STAGES       2

`endif

// ### hdl/iox_pin_cell.sv
// Per-pin output stage: high-side and low-side driver control.
// Assumes direction and output bits come from clk_sys registers.
module iox_pin_cell #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] cfg_input,
  input  wire logic [WIDTH-1:0] out_val,
  output logic      [WIDTH-1:0] high_side_driver,
  output logic      [WIDTH-1:0] low_side_driver,
  output iox_pkg::iox_pad_t [WIDTH-1:0] pad
);

  ////////////////////////////////////////////////////////////////////////
  // One driver pair per pin; both off while the pin is an input
  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        high_side_driver[i] <= 1'b0;
        low_side_driver[i]  <= 1'b0;
      end else begin
        high_side_driver[i] <= ~cfg_input[i] & out_val[i];
        low_side_driver[i]  <= ~cfg_input[i] & ~out_val[i];
      end
    end
    // Pad view: drive level of high side, enable while either is on
    assign pad[i].o  = high_side_driver[i];
    assign pad[i].oe = high_side_driver[i] | low_side_driver[i];
  end

endmodule // iox_pin_cell

// ### hdl/iox_pkg.sv
// Types shared by the port expander core.
// Assumes nothing beyond a SystemVerilog compiler.
package iox_pkg;

  // One APB request as seen by the slave
  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } iox_apb_req_t;

  // One open-drain or push-pull pad: output value and enable
  typedef struct packed {
    logic o;
    logic oe;
  } iox_pad_t;

endpackage

// ### hdl/iox_sync.sv
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level from outside the clk_sys domain.
module iox_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  ////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second stage
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // iox_sync

// ### hdl/iox_top.sv
// Port expander core: port registers, pin drivers, change interrupt.
// Assumes an APB master on clk_sys and a serial engine that flags the
// acknowledge bit of a read of this port; SCL itself arrives as a pin.
//
// What this block does
// - Reset pin low forces every register default.
// - Pins change again after reset pin rises.
// - Power-on reset holds defaults until supply good.
// - Input pin: both drivers off, high impedance.
// - Output pin: driver chosen by output bit.
// - Input pin edge, either way, raises interrupt.
// - Interrupt valid within 4 us of change.
// - Clear on return to original or read.
// - Read clear at ack bit, SCL rise.
// - Interrupt released within 4 us of SCL.
// - Change during clearing ack may be lost.
// - Every change after clear interrupts again.
// - Traffic for other devices leaves interrupt alone.
// - Output pins never raise the interrupt.
// - Output-to-input switch may interrupt spuriously.
// - Interrupt is active-low open drain.
// - Input register shows every pin level.
// - Output bits ignored on input pins.
`include "iox_params.svh"

module iox_top #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             reset_pin_n,
  input  wire logic             por_ok,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Serial link hooks
  input  wire logic             scl_i,
  input  wire logic             rd_ack_phase,
  // Port pins
  input  wire logic [WIDTH-1:0] port_pins_i,
  output logic      [WIDTH-1:0] port_pins_o,
  output logic      [WIDTH-1:0] port_pins_oe,
  output logic      [WIDTH-1:0] high_side_driver,
  output logic      [WIDTH-1:0] low_side_driver,
  // Interrupt, open drain
  output logic                  irq_n_o,
  output logic                  irq_n_oe
);

  // Timing budgets the pipeline below stays well inside
  localparam int IrqValidCyc = `IOX_IRQ_VALID_CYC;
  localparam int IrqClearCyc = `IOX_IRQ_CLEAR_CYC;

  iox_pkg::iox_apb_req_t        req;
  iox_pkg::iox_pad_t [WIDTH-1:0] pad;

  logic                          core_rst;
  logic [`IOX_RST_STAGES-1:0]    rst_pipe_q;
  logic                          rst_any;
  logic [WIDTH-1:0]              pins_sync;
  logic                          scl_sync;
  logic                          scl_prev_q;
  logic                          scl_rise;
  logic                          rd_ack_q;
  logic                          clear_evt;
  logic [WIDTH-1:0]              output_q;
  logic [WIDTH-1:0]              polarity_q;
  logic [WIDTH-1:0]              config_q;
  logic [WIDTH-1:0]              input_q;
  logic [WIDTH-1:0]              snapshot_q;
  logic [WIDTH-1:0]              change_d;
  logic                          irq_q;
  logic                          ready_q;
  logic [1:0]                    fill_q;
  logic [31:0]                   rdata_q;
  logic [31:0]                   rdata_d;
  logic                          addr_ok;
  logic                          wr_en;

  ////////////////////////////////////////////////////////////////////////
  // Reset: any source asserts at once, release is synchronised.
  // Asynchronous assert so even a 4 ns pin pulse is never missed.
  assign rst_any = sys_rst | ~reset_pin_n | ~por_ok;

  always_ff @(posedge clk_sys or posedge rst_any) begin
    if (rst_any) begin
      rst_pipe_q <= '1;
    end else begin
      rst_pipe_q <= {rst_pipe_q[`IOX_RST_STAGES-2:0], 1'b0};
    end
  end

  assign core_rst = rst_pipe_q[`IOX_RST_STAGES-1];

  ////////////////////////////////////////////////////////////////////////
  // Pin and SCL synchronisers
  iox_sync #(
    .WIDTH    (WIDTH)
  ) u_pin_sync (
    .clk_sys  (clk_sys),
    .rst      (core_rst),
    .async_in (port_pins_i),
    .sync_out (pins_sync)
  );

  iox_sync #(
    .WIDTH    (1)
  ) u_scl_sync (
    .clk_sys  (clk_sys),
    .rst      (core_rst),
    .async_in (scl_i),
    .sync_out (scl_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // SCL rising edge, qualified by the ack bit of a read of this port.
  // The qualifier comes from our own serial engine only, so writes or
  // reads addressed to other bus devices never clear anything.
  always_ff @(posedge clk_sys or posedge core_rst) begin
    if (core_rst) begin
      scl_prev_q <= 1'b0;
    end else begin
      scl_prev_q <= scl_sync;
    end
  end

  // Qualifier delayed one edge so it still stands at the synced SCL rise
  always_ff @(posedge clk_sys or posedge core_rst) begin
    if (core_rst) begin
      rd_ack_q <= 1'b0;
    end else begin
      rd_ack_q <= rd_ack_phase;
    end
  end

  // The synchroniser leaves reset low while SCL idles high, which looks
  // like a rise; ready_q masks it until the input path has filled.
  assign scl_rise  = scl_sync & ~scl_prev_q;
  assign clear_evt = scl_rise & rd_ack_q & ready_q;

  ////////////////////////////////////////////////////////////////////////
  // APB request bundle and decode
  assign req.psel    = psel;
  assign req.penable = penable;
  assign req.pwrite  = pwrite;
  assign req.paddr   = paddr;
  assign req.pwdata  = pwdata;

  always_comb begin
    case (req.paddr)
      `IOX_OFS_INPUT,
      `IOX_OFS_OUTPUT,
      `IOX_OFS_POLARITY,
      `IOX_OFS_CONFIG,
      `IOX_OFS_STATUS: addr_ok = 1'b1;
      default:         addr_ok = 1'b0;
    endcase
  end

  assign wr_en = req.psel & req.penable & req.pwrite & addr_ok;

  ////////////////////////////////////////////////////////////////////////
  // Output, polarity and direction registers
  always_ff @(posedge clk_sys or posedge core_rst) begin
    if (core_rst) begin
      output_q   <= `IOX_RST_OUTPUT;
      polarity_q <= `IOX_RST_POLARITY;
      config_q   <= `IOX_RST_CONFIG;                   // All pins input
    end else if (wr_en) begin
      case (req.paddr)
        `IOX_OFS_OUTPUT:   output_q   <= req.pwdata[WIDTH-1:0];
        `IOX_OFS_POLARITY: polarity_q <= req.pwdata[WIDTH-1:0];
        `IOX_OFS_CONFIG:   config_q   <= req.pwdata[WIDTH-1:0];
        default: ;                                    // Input is read-only
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input register follows every pin, inputs and outputs alike
  always_ff @(posedge clk_sys or posedge core_rst) begin
    if (core_rst) begin
      input_q <= '0;
    end else begin
      input_q <= pins_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fill count: the input register holds real pin levels only three
  // edges after reset release (two sync flops and itself); arming any
  // earlier would make every high pin look like a change.
  always_ff @(posedge clk_sys or posedge core_rst) begin
    if (core_rst) begin
      fill_q <= 2'h0;
    end else if (fill_q != 2'h3) begin
      fill_q <= fill_q + 2'h1;
    end
  end

  // Armed once the input path has filled; stays armed until reset
  always_ff @(posedge clk_sys or posedge core_rst) begin
    if (core_rst) begin
      ready_q <= 1'b0;
    end else if (fill_q == 2'h3) begin
      ready_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Snapshot taken at each clearing read; follows the live pins until
  // armed so a fresh device starts with no pending change.
  // Hazard: a change landing in the same cycle is absorbed, as allowed.
  always_ff @(posedge clk_sys or posedge core_rst) begin
    if (core_rst) begin
      snapshot_q <= '0;
    end else if (!ready_q || clear_evt) begin
      snapshot_q <= input_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Change detect: only input-mode pins that differ from the snapshot.
  // Pending tracks the difference, so a pin that reverts clears it and
  // any later change sets it again.
  // Limitation: an output turned back to input whose level differs from
  // the snapshot raises the interrupt at once; software must expect it.
  assign change_d = (input_q ^ snapshot_q) & config_q;

  always_ff @(posedge clk_sys or posedge core_rst) begin
    if (core_rst) begin
      irq_q <= 1'b0;
    end else if (clear_evt) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= ready_q & (|change_d);
    end
  end

  // Open drain: pull low while pending, float otherwise
  assign irq_n_o  = 1'b0;
  assign irq_n_oe = irq_q;

  ////////////////////////////////////////////////////////////////////////
  // Pin drivers
  iox_pin_cell #(
    .WIDTH            (WIDTH)
  ) u_pins (
    .clk_sys          (clk_sys),
    .rst              (core_rst),
    .cfg_input        (config_q),
    .out_val          (output_q),
    .high_side_driver (high_side_driver),
    .low_side_driver  (low_side_driver),
    .pad              (pad)
  );

  // Flatten pad structs onto the three-signal pin ports
  for (genvar i = 0; i < WIDTH; i++) begin : g_pad
    assign port_pins_o[i]  = pad[i].o;
    assign port_pins_oe[i] = pad[i].oe;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux, captured in the setup cycle so prdata is a flop
  // Polarity bends only the read value, never the change detection
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (req.paddr)
      `IOX_OFS_INPUT:    rdata_d[WIDTH-1:0] = input_q ^ polarity_q;
      `IOX_OFS_OUTPUT:   rdata_d[WIDTH-1:0] = output_q;
      `IOX_OFS_POLARITY: rdata_d[WIDTH-1:0] = polarity_q;
      `IOX_OFS_CONFIG:   rdata_d[WIDTH-1:0] = config_q;
      `IOX_OFS_STATUS: begin
        rdata_d[`IOX_STS_IRQ_BIT] = irq_q;
        rdata_d[`IOX_STS_RDY_BIT] = ready_q;
      end
      default:           rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or posedge core_rst) begin
    if (core_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (req.psel && !req.penable) begin
      rdata_q <= rdata_d;
    end
  end

  // Zero wait states; error only on unmapped addresses
  assign pready  = 1'b1;
  assign pslverr = req.psel & req.penable & ~addr_ok;
  assign prdata  = rdata_q;

endmodule // iox_top

// ### verif/io_expander_reset_port_irq_test.sv
// Self-checking bench for iox_top: APB accesses, pin and serial traffic.
// Assumes iox_far_model at the pins and iox_monitor bound to the core.
`include "iox_params.svh"
module io_expander_reset_port_irq_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        reset_pin_n = 1'b1;
  logic        por_ok = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [7:0]  ext_lvl = 8'hA5;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, scl_i, rd_ack_phase, irq_n_o, irq_n_oe, err;
  logic [7:0]  pins_i, pins_o, pins_oe, hs_drv, ls_drv;
  int          n_errors = 0;
  int          samples_checked = 0;
  logic [7:0]  ofs [3] = '{`IOX_OFS_OUTPUT, `IOX_OFS_POLARITY, `IOX_OFS_CONFIG};
  logic [7:0]  rstv [3] = '{`IOX_RST_OUTPUT, `IOX_RST_POLARITY, `IOX_RST_CONFIG};
  wire         irq_line = irq_n_oe ? irq_n_o : 1'b1; // Pull-up while released
  always #50 clk_sys = ~clk_sys;
  iox_top dut_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n), .por_ok(por_ok),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_i), .rd_ack_phase(rd_ack_phase),
    .port_pins_i(pins_i), .port_pins_o(pins_o), .port_pins_oe(pins_oe), .high_side_driver(hs_drv),
    .low_side_driver(ls_drv), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe)
  );
  iox_far_model far_u (
    .clk_sys(clk_sys), .ext_lvl(ext_lvl), .port_pins_o(pins_o), .port_pins_oe(pins_oe),
    .port_pins_i(pins_i), .scl_i(scl_i), .rd_ack_phase(rd_ack_phase)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_irq(input logic e);
    chk({31'h0, irq_line}, {31'h0, e}, "interrupt line");
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Setup then access; held until pready is sampled high, bounded wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk(32'h0, 32'h1, "pready timeout");
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys); // Idle edge: a next setup never re-drives psel in this step
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(6);
    sys_rst <= 1'b0;
    cyc(10);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, ofs[i], 32'h0);
      chk(rd, {24'h0, rstv[i]}, "reset value");
    end
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    apb(1'b0, `IOX_OFS_INPUT, 32'h0);
    chk(rd, {24'h0, ext_lvl}, "input levels");
    $display("Test registers done");
    // Edges both ways, return, foreign traffic, clearing reads
    ext_lvl <= 8'hA4;
    cyc(40);
    chk_irq(1'b0);
    apb(1'b0, `IOX_OFS_STATUS, 32'h0);
    chk(rd, 32'h3, "status pending");
    ext_lvl <= 8'hA5;
    cyc(40);
    chk_irq(1'b1);
    apb(1'b0, `IOX_OFS_STATUS, 32'h0);
    chk(rd, 32'h2, "status after revert");
    ext_lvl <= 8'hA7;
    cyc(40);
    chk_irq(1'b0);
    far_u.frame(1'b0);
    chk_irq(1'b0);
    far_u.frame(1'b1);
    chk_irq(1'b1);
    ext_lvl <= 8'hA5;
    cyc(40);
    chk_irq(1'b0);
    far_u.frame(1'b1);
    chk_irq(1'b1);
    $display("Test interrupt done");
    // Low nibble as outputs; their moves must stay silent
    apb(1'b1, `IOX_OFS_OUTPUT, 32'h0000000F);
    apb(1'b1, `IOX_OFS_CONFIG, 32'h000000F0);
    cyc(2);
    chk({24'h0, hs_drv}, 32'h0F, "high side");
    chk({24'h0, pins_oe}, 32'h0F, "pin enables");
    cyc(40);
    chk_irq(1'b1);
    apb(1'b0, `IOX_OFS_INPUT, 32'h0);
    chk(rd, 32'hAF, "input with outputs");
    apb(1'b1, `IOX_OFS_POLARITY, 32'h000000FF);
    apb(1'b0, `IOX_OFS_INPUT, 32'h0);
    chk(rd, 32'h50, "inverted input");
    apb(1'b1, `IOX_OFS_POLARITY, 32'h00000000);
    apb(1'b1, `IOX_OFS_OUTPUT, 32'h000000F0);
    cyc(2);
    chk({24'h0, hs_drv}, 32'h00, "high side on inputs");
    chk({24'h0, ls_drv}, 32'h0F, "low side");
    cyc(40);
    chk_irq(1'b1);
    $display("Test outputs done");
    // Reset pin then power good, each from an output setup
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `IOX_OFS_CONFIG, 32'h000000F0);
      cyc(2);
      if (k == 0) reset_pin_n <= 1'b0;
      else por_ok <= 1'b0;
      cyc(1);
      chk({24'h0, pins_oe}, 32'h0, "enables in reset");
      reset_pin_n <= 1'b1;
      por_ok <= 1'b1;
      cyc(10);
      apb(1'b0, `IOX_OFS_CONFIG, 32'h0);
      chk(rd, {24'h0, `IOX_RST_CONFIG}, "config after reset");
      ext_lvl <= ext_lvl ^ 8'h10;
      cyc(40);
      chk_irq(1'b0);
      far_u.frame(1'b1);
      chk_irq(1'b1);
    end
    $display("Test reset done");
    complete_run();
  end
endmodule // io_expander_reset_port_irq_test

// ### verif/iox_far_model.sv
// Far side of the core: pin network and a serial master clocking frames.
// Assumes clk_sys from the bench; SCL stands high between frames.
module iox_far_model #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic [WIDTH-1:0] ext_lvl,
  input  wire logic [WIDTH-1:0] port_pins_o,
  input  wire logic [WIDTH-1:0] port_pins_oe,
  output logic      [WIDTH-1:0] port_pins_i,
  output logic                  scl_i,
  output logic                  rd_ack_phase
);
  timeunit 1ns;
  timeprecision 1ps;
  // Core drive wins where enabled, else the outside source
  assign port_pins_i = (port_pins_o & port_pins_oe) | (ext_lvl & ~port_pins_oe);
  initial begin
    scl_i = 1'b1;
    rd_ack_phase = 1'b0;
  end
  // One byte plus ack at 800 ns a bit; SCL moves on clk_sys edges only
  task automatic frame(input logic mine);
    for (int b = 0; b < 9; b++) begin
      scl_i <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rd_ack_phase <= mine && (b == 8);
      scl_i <= 1'b1;
      repeat (4) @(posedge clk_sys);
    end
    rd_ack_phase <= 1'b0;
  endtask
endmodule // iox_far_model

// ### verif/iox_monitor.sv
// Concurrent checks on the port expander core, bound into iox_top.
// Assumes one clk_sys domain with sys_rst asynchronous, active high.
module iox_monitor #(
  parameter int WIDTH = 8
) (
  input wire logic             clk_sys,
  input wire logic             sys_rst,
  input wire logic             reset_pin_n,
  input wire logic             por_ok,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pready,
  input wire logic             scl_i,
  input wire logic             rd_ack_phase,
  input wire logic [WIDTH-1:0] port_pins_i,
  input wire logic [WIDTH-1:0] port_pins_oe,
  input wire logic [WIDTH-1:0] high_side_driver,
  input wire logic [WIDTH-1:0] low_side_driver,
  input wire logic             irq_n_o,
  input wire logic             irq_n_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  // Cycles since the pins last moved; reset sources restart it too
  logic [7:0]       since_chg_q;
  logic [WIDTH-1:0] pins_q;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      since_chg_q <= 8'h00;
      pins_q <= '0;
    end else begin
      pins_q <= port_pins_i;
      if (port_pins_i != pins_q || !reset_pin_n || !por_ok) since_chg_q <= 8'h00;
      else if (since_chg_q != 8'hFF) since_chg_q <= since_chg_q + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge bit of a read of our port, seen at the SCL rise
  sequence s_ack_rise;
    rd_ack_phase && $rose(scl_i);
  endsequence
  property p_pin_rst;
    !reset_pin_n |-> !irq_n_oe && (port_pins_oe == '0);
  endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("outputs active under reset pin");
  property p_por_rst;
    !por_ok |-> !irq_n_oe && ((high_side_driver | low_side_driver) == '0);
  endproperty
  a_por_rst: assert property (p_por_rst) else $error("outputs active before power good");
  property p_hiz;
    port_pins_oe == (high_side_driver | low_side_driver);
  endproperty
  a_hiz: assert property (p_hiz) else $error("pin enable without a driver");
  property p_excl;
    (high_side_driver & low_side_driver) == '0;
  endproperty
  a_excl: assert property (p_excl) else $error("both drivers on");
  property p_od;
    irq_n_o == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("interrupt pad drives high");
  property p_clr;
    s_ack_rise |-> ##[1:40] !irq_n_oe;
  endproperty
  a_clr: assert property (p_clr) else $error("interrupt not released after read");
  property p_rise;
    $rose(irq_n_oe) |-> since_chg_q <= 8'h28;
  endproperty
  a_rise: assert property (p_rise) else $error("interrupt without recent pin change");
  property p_ready;
    psel && penable |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("access not completed");
endmodule // iox_monitor

bind iox_top iox_monitor #(.WIDTH(WIDTH)) mon_u (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n), .por_ok(por_ok),
  .psel(psel), .penable(penable), .pready(pready), .scl_i(scl_i), .rd_ack_phase(rd_ack_phase),
  .port_pins_i(port_pins_i), .port_pins_oe(port_pins_oe), .high_side_driver(high_side_driver),
  .low_side_driver(low_side_driver), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe)
);
